// ---- sfc_defs.vh ----
// constants for the synthesizer frequency-control block
// Operation
// - band integer above 23 reads as 23
// - integer divide equals band integer plus 24
// - modulator accumulator wraps modulo 64000
// - modulator clocked by reference; carrier formula holds
// - band flag picks high band or divider
// - fraction sums carrier, offset and deviation
// - receive lowers synthesizer by 937.5 kHz
// - hop step counts in 10 kHz units
// - carrier adds channel times step times 10kHz
// - hop write in tx/rx retunes, then resumes
// - VCO calibration on change, power-up, force
// - fine RC calibration every 30 s enabled
// - forced full RC calibration lasts 2 ms
// - settle wait after bias wait, programmable
// - deviation step is 625 Hz both bands
// - signed offset step 156.25 Hz times band
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH
// ----------------------------------------
// register indices
// ----------------------------------------
`define SFC_ADDR_PLL_TUNE_TIMING 7'h53
`define SFC_ADDR_CALIBRATION_CONTROL 7'h55
`define SFC_ADDR_DEVIATION_HI 7'h71
`define SFC_ADDR_DEVIATION_LO 7'h72
`define SFC_ADDR_OFFSET_LO 7'h73
`define SFC_ADDR_OFFSET_HI 7'h74
`define SFC_ADDR_BAND_SELECT 7'h75
`define SFC_ADDR_FRACTION_HI 7'h76
`define SFC_ADDR_FRACTION_LO 7'h77
`define SFC_ADDR_HOP_CHANNEL 7'h79
`define SFC_ADDR_HOP_STEP 7'h7A
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SFC_TUNE_BIAS_LSB 0
`define SFC_TUNE_SETTLE_LSB 3
`define SFC_CAL_VCO_FORCE_BIT 0
`define SFC_CAL_RC_FINE_EN_BIT 1
`define SFC_CAL_RC_FULL_BIT 2
`define SFC_BAND_HIGH_BIT 5
`define SFC_RST_PLL_TUNE_TIMING 8'hA2
`define SFC_RST_CALIBRATION_CONTROL 8'h00
`define SFC_RST_BAND_SELECT 8'h35
`define SFC_RST_BAND_INT 5'h15
`define SFC_RST_BAND_HIGH 1'b1
`define SFC_RST_FRACTION 16'h7D00
`define SFC_RST_DEVIATION 9'h000
`define SFC_RST_OFFSET 10'h000
// ----------------------------------------
// frequency arithmetic
// ----------------------------------------
`define SFC_BAND_INT_MAX 5'h17
`define SFC_N_OFFSET 7'h18
`define SFC_FRAC_MOD 32'h0000FA00
`define SFC_IF_UNITS_LOW 32'h00001770
`define SFC_HOP_UNITS_LOW 32'h00000040
`define SFC_DEV_UNITS_LOW 32'h00000004
// ----------------------------------------
// timing
// ----------------------------------------
`define SFC_CLK_PERIOD_NS 10
`define SFC_BIAS_UNIT_NS 5000
`define SFC_BIAS_UNIT_CYC (`SFC_BIAS_UNIT_NS / `SFC_CLK_PERIOD_NS)
`define SFC_SETTLE_UNIT_NS 10000
`define SFC_SETTLE_UNIT_CYC (`SFC_SETTLE_UNIT_NS / `SFC_CLK_PERIOD_NS)
`define SFC_RC_FINE_PERIOD_S 30
`define SFC_RC_FINE_CYC (`SFC_RC_FINE_PERIOD_S * (32'd1000000000 / `SFC_CLK_PERIOD_NS))
`define SFC_RC_FULL_US 2000
`define SFC_RC_FULL_CYC (`SFC_RC_FULL_US * 1000 / `SFC_CLK_PERIOD_NS)
`define SFC_VCO_CAL_NS 10000
`define SFC_VCO_CAL_CYC (`SFC_VCO_CAL_NS / `SFC_CLK_PERIOD_NS)
`endif

// ---- sfc_synth_ctrl.v ----
// synthesizer frequency-control block: registers, divide word, modulator, sequencer
`timescale 1ns/1ns
`include "sfc_defs.vh"
module sfc_synth_ctrl #(
	parameter [31:0] RC_FINE_CYC = `SFC_RC_FINE_CYC,
	parameter [31:0] RC_FULL_CYC = `SFC_RC_FULL_CYC,
	parameter [31:0] VCO_CAL_CYC = `SFC_VCO_CAL_CYC,
	parameter [31:0] BIAS_UNIT_CYC = `SFC_BIAS_UNIT_CYC,
	parameter [31:0] SETTLE_UNIT_CYC = `SFC_SETTLE_UNIT_CYC
) (
	input wire clk_sys,
	input wire arst_n,
	input wire [6:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	input wire tx_req,
	input wire rx_req,
	input wire tx_data,
	output reg [7:0] reg_rdata,
	output reg [6:0] div_int,
	output reg [15:0] div_frac,
	output reg [6:0] dsm_div,
	output reg div_half_en,
	output reg pll_en,
	output reg vco_cal_busy,
	output reg tx_active,
	output reg rx_active,
	output reg rc_fine_cal,
	output reg rc_full_busy
);
	// ----------------------------------------
	// sequencer states, one-hot
	// ----------------------------------------
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_BIAS = 6'h02;
	localparam [5:0] ST_VCAL = 6'h04;
	localparam [5:0] ST_SETTLE = 6'h08;
	localparam [5:0] ST_TX = 6'h10;
	localparam [5:0] ST_RX = 6'h20;

	// ----------------------------------------
	// register file storage
	// ----------------------------------------
	reg [7:0] tune_reg; // bias and settle fields
	reg [7:0] cal_ctrl_reg; // force and enable bits
	reg [8:0] dev_word_reg; // deviation word
	reg [9:0] ofs_word_reg; // signed offset word
	reg [4:0] band_int_reg; // clamped band integer
	reg band_high_reg; // high band flag
	reg [15:0] frac_word_reg; // carrier fraction word
	reg [7:0] hop_chan_reg; // hop channel number
	reg [7:0] hop_step_reg; // hop step size

	// ----------------------------------------
	// control state
	// ----------------------------------------
	reg [5:0] state_reg;
	reg [5:0] state_next;
	reg [31:0] cnt_reg; // shared sequencer countdown
	reg [31:0] cnt_next;
	reg cal_pend_reg; // VCO calibration owed
	reg [31:0] nominal_reg; // channel word without deviation or IF
	reg hop_wr_reg; // hop register touched, retune owed
	reg [15:0] acc_reg; // modulator accumulator
	reg [31:0] rc_period_cnt_reg; // fine RC interval counter
	reg [31:0] rc_full_cnt_reg; // full RC calibration counter

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	wire wr_tune = reg_we && (reg_addr == `SFC_ADDR_PLL_TUNE_TIMING);
	wire wr_cal = reg_we && (reg_addr == `SFC_ADDR_CALIBRATION_CONTROL);
	wire wr_hop = reg_we && ((reg_addr == `SFC_ADDR_HOP_CHANNEL) || (reg_addr == `SFC_ADDR_HOP_STEP));
	wire [4:0] bias_field = {2'b00, tune_reg[`SFC_TUNE_BIAS_LSB +: 3]};
	wire [4:0] settle_field = tune_reg[`SFC_TUNE_SETTLE_LSB +: 5];
	wire rx_sel = rx_req && !tx_req; // transmit wins when both asked
	// wait length for a field, never below one cycle
	function [31:0] wait_cyc;
		input [4:0] field;
		input [31:0] unit;
		wait_cyc = (field == 5'h00) ? 32'h00000000 : field * unit - 32'h00000001;
	endfunction
	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// force bits self-clear, VCO force once taken and full RC when its run ends, but a new write of 1 in that cycle wins
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tune_reg <= `SFC_RST_PLL_TUNE_TIMING;
			cal_ctrl_reg <= `SFC_RST_CALIBRATION_CONTROL;
			dev_word_reg <= `SFC_RST_DEVIATION;
			ofs_word_reg <= `SFC_RST_OFFSET;
			band_int_reg <= `SFC_RST_BAND_INT;
			band_high_reg <= `SFC_RST_BAND_HIGH;
			frac_word_reg <= `SFC_RST_FRACTION;
			hop_chan_reg <= 8'h00;
			hop_step_reg <= 8'h00;
		end else begin
			cal_ctrl_reg[`SFC_CAL_VCO_FORCE_BIT] <= 1'b0; // taken into the pending flag
			if (rc_full_cnt_reg == 32'h00000001) begin
				cal_ctrl_reg[`SFC_CAL_RC_FULL_BIT] <= 1'b0; // full RC run done
			end
			if (wr_tune) begin
				tune_reg <= reg_wdata;
			end else if (wr_cal) begin
				cal_ctrl_reg <= reg_wdata;
			end else if (reg_we && reg_addr == `SFC_ADDR_DEVIATION_HI) begin
				dev_word_reg[8] <= reg_wdata[0];
			end else if (reg_we && reg_addr == `SFC_ADDR_DEVIATION_LO) begin
				dev_word_reg[7:0] <= reg_wdata;
			end else if (reg_we && reg_addr == `SFC_ADDR_OFFSET_LO) begin
				ofs_word_reg[7:0] <= reg_wdata;
			end else if (reg_we && reg_addr == `SFC_ADDR_OFFSET_HI) begin
				ofs_word_reg[9:8] <= reg_wdata[1:0];
			end else if (reg_we && reg_addr == `SFC_ADDR_BAND_SELECT) begin
				band_high_reg <= reg_wdata[`SFC_BAND_HIGH_BIT];
				band_int_reg <= (reg_wdata[4:0] > `SFC_BAND_INT_MAX) ? `SFC_BAND_INT_MAX : reg_wdata[4:0];
			end else if (reg_we && reg_addr == `SFC_ADDR_FRACTION_HI) begin
				frac_word_reg[15:8] <= reg_wdata;
			end else if (reg_we && reg_addr == `SFC_ADDR_FRACTION_LO) begin
				frac_word_reg[7:0] <= reg_wdata;
			end else if (reg_we && reg_addr == `SFC_ADDR_HOP_CHANNEL) begin
				hop_chan_reg <= reg_wdata;
			end else if (reg_we && reg_addr == `SFC_ADDR_HOP_STEP) begin
				hop_step_reg <= reg_wdata;
			end
		end
	end
	// ----------------------------------------
	// register reads, one cycle after the strobe
	// ----------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_re) begin
			if (reg_addr == `SFC_ADDR_PLL_TUNE_TIMING) begin
				reg_rdata <= tune_reg;
			end else if (reg_addr == `SFC_ADDR_CALIBRATION_CONTROL) begin
				reg_rdata <= cal_ctrl_reg;
			end else if (reg_addr == `SFC_ADDR_DEVIATION_HI) begin
				reg_rdata <= {7'h00, dev_word_reg[8]};
			end else if (reg_addr == `SFC_ADDR_DEVIATION_LO) begin
				reg_rdata <= dev_word_reg[7:0];
			end else if (reg_addr == `SFC_ADDR_OFFSET_LO) begin
				reg_rdata <= ofs_word_reg[7:0];
			end else if (reg_addr == `SFC_ADDR_OFFSET_HI) begin
				reg_rdata <= {6'h00, ofs_word_reg[9:8]};
			end else if (reg_addr == `SFC_ADDR_BAND_SELECT) begin
				reg_rdata <= {2'h0, band_high_reg, band_int_reg};
			end else if (reg_addr == `SFC_ADDR_FRACTION_HI) begin
				reg_rdata <= frac_word_reg[15:8];
			end else if (reg_addr == `SFC_ADDR_FRACTION_LO) begin
				reg_rdata <= frac_word_reg[7:0];
			end else if (reg_addr == `SFC_ADDR_HOP_CHANNEL) begin
				reg_rdata <= hop_chan_reg;
			end else if (reg_addr == `SFC_ADDR_HOP_STEP) begin
				reg_rdata <= hop_step_reg;
			end else begin
				reg_rdata <= 8'h00; // unmapped reads as zero
			end
		end
	end

	// ----------------------------------------
	// divide word arithmetic
	// ----------------------------------------
	// all terms are in fraction LSBs of 156.25 Hz times (band flag + 1);
	// the high band halves every fixed-Hz term, so those shift right once
	reg [31:0] nominal_next;
	reg [31:0] word_next;
	reg [31:0] dev_units;
	reg [31:0] int_full;
	reg [31:0] frac_full; // remainder left after the integer part
	always @* begin
		nominal_next = ({27'h0, band_int_reg} + {25'h0, `SFC_N_OFFSET}) * `SFC_FRAC_MOD;
		nominal_next = nominal_next + {16'h0, frac_word_reg};
		nominal_next = nominal_next + {{22{ofs_word_reg[9]}}, ofs_word_reg};
		nominal_next = nominal_next + ((({24'h0, hop_step_reg} * {24'h0, hop_chan_reg}) * `SFC_HOP_UNITS_LOW)
			>> band_high_reg);
		dev_units = ({23'h0, dev_word_reg} * `SFC_DEV_UNITS_LOW) >> band_high_reg;
		word_next = nominal_reg;
		if (state_reg == ST_TX) begin
			word_next = tx_data ? nominal_reg + dev_units : nominal_reg - dev_units;
		end else if (rx_sel) begin
			word_next = nominal_reg - (`SFC_IF_UNITS_LOW >> band_high_reg);
		end
		int_full = word_next / `SFC_FRAC_MOD;
		frac_full = word_next - int_full * `SFC_FRAC_MOD;
	end
	// integer and fraction move together on one edge, so the modulator
	// never sees a half-updated pair
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			nominal_reg <= 32'h00000000;
			div_int <= 7'h00;
			div_frac <= 16'h0000;
			div_half_en <= 1'b0;
		end else begin
			nominal_reg <= nominal_next;
			div_int <= int_full[6:0];
			div_frac <= frac_full[15:0];
			div_half_en <= !band_high_reg;
		end
	end

	// ----------------------------------------
	// modulator accumulator on the reference clock
	// ----------------------------------------
	// first-order stage only; the carry dithers the integer so the mean is N + F
	wire [16:0] acc_sum = {1'b0, acc_reg} + {1'b0, div_frac};
	wire acc_carry = (acc_sum >= `SFC_FRAC_MOD);
	wire [31:0] acc_wrap = {15'h0000, acc_sum} - `SFC_FRAC_MOD; // sum less one modulus
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= 16'h0000;
			dsm_div <= 7'h00;
		end else begin
			acc_reg <= acc_carry ? acc_wrap[15:0] : acc_sum[15:0];
			dsm_div <= div_int + {6'h00, acc_carry};
		end
	end
	// ----------------------------------------
	// VCO calibration bookkeeping
	// ----------------------------------------
	// pending at reset for the power-up run; a new event beats the clear
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cal_pend_reg <= 1'b1;
			hop_wr_reg <= 1'b0;
		end else begin
			cal_pend_reg <= (cal_pend_reg && state_next != ST_VCAL) || (nominal_next != nominal_reg)
				|| cal_ctrl_reg[`SFC_CAL_VCO_FORCE_BIT];
			hop_wr_reg <= (hop_wr_reg && state_next != ST_BIAS) || wr_hop;
		end
	end
	// ----------------------------------------
	// tune sequencer
	// ----------------------------------------
	always @* begin
		state_next = state_reg;
		cnt_next = (cnt_reg == 32'h00000000) ? cnt_reg : cnt_reg - 32'h00000001;
		case (state_reg)
			ST_IDLE: begin
				if (tx_req || rx_req) begin
					state_next = ST_BIAS;
					cnt_next = wait_cyc(bias_field, BIAS_UNIT_CYC);
				end
			end
			ST_BIAS: begin
				if (cnt_reg == 32'h00000000) begin
					if (cal_pend_reg) begin
						state_next = ST_VCAL;
						cnt_next = VCO_CAL_CYC - 32'h00000001;
					end else begin
						state_next = ST_SETTLE;
						cnt_next = wait_cyc(settle_field, SETTLE_UNIT_CYC);
					end
				end
			end
			ST_VCAL: begin
				if (cnt_reg == 32'h00000000) begin
					state_next = ST_SETTLE;
					cnt_next = wait_cyc(settle_field, SETTLE_UNIT_CYC);
				end
			end
			ST_SETTLE: begin
				if (cnt_reg == 32'h00000000) begin
					state_next = tx_req ? ST_TX : (rx_req ? ST_RX : ST_IDLE);
				end
			end
			default: begin
				// transmit or receive: a hop write or owed calibration retunes, then resumes
				if (!(tx_req || rx_req)) begin
					state_next = ST_IDLE;
				end else if (hop_wr_reg || cal_pend_reg) begin
					state_next = ST_BIAS;
					cnt_next = wait_cyc(bias_field, BIAS_UNIT_CYC);
				end else if (state_reg == ST_TX && !tx_req) begin
					state_next = ST_RX;
				end else if (state_reg == ST_RX && tx_req) begin
					state_next = ST_TX;
				end
			end
		endcase
	end

	// sequencer flops and its status outputs
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 32'h00000000;
			pll_en <= 1'b0;
			vco_cal_busy <= 1'b0;
			tx_active <= 1'b0;
			rx_active <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			pll_en <= (state_next != ST_IDLE);
			vco_cal_busy <= (state_next == ST_VCAL);
			tx_active <= (state_next == ST_TX);
			rx_active <= (state_next == ST_RX);
		end
	end

	// ----------------------------------------
	// RC oscillator calibration timers
	// ----------------------------------------
	// the fine interval restarts whenever the enable drops
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rc_period_cnt_reg <= 32'h00000000;
			rc_fine_cal <= 1'b0;
			rc_full_cnt_reg <= 32'h00000000;
			rc_full_busy <= 1'b0;
		end else begin
			rc_fine_cal <= 1'b0;
			if (!cal_ctrl_reg[`SFC_CAL_RC_FINE_EN_BIT]) begin
				rc_period_cnt_reg <= 32'h00000000;
			end else if (rc_period_cnt_reg >= RC_FINE_CYC - 32'h00000001) begin
				rc_period_cnt_reg <= 32'h00000000;
				rc_fine_cal <= 1'b1;
			end else begin
				rc_period_cnt_reg <= rc_period_cnt_reg + 32'h00000001;
			end
			if (rc_full_cnt_reg != 32'h00000000) begin
				rc_full_cnt_reg <= rc_full_cnt_reg - 32'h00000001;
				rc_full_busy <= (rc_full_cnt_reg != 32'h00000001);
			end else if (cal_ctrl_reg[`SFC_CAL_RC_FULL_BIT]) begin
				rc_full_cnt_reg <= RC_FULL_CYC;
				rc_full_busy <= 1'b1;
			end
		end
	end
endmodule

// ---- sfc_host_model.sv ----
// host-side model that drives the register port of the synthesizer block
`timescale 1ns/1ns
module sfc_host_model (
	input logic clk_sys,
	output logic [6:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input logic [7:0] reg_rdata
);
	// ----------------------------------------
	// register port cycles
	// ----------------------------------------
	// bus idle from time zero, strobes low
	initial begin
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
		reg_we = 1'b0;
		reg_re = 1'b0;
	end
	// one write, held across one rising edge; released lines show the inverse
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(negedge clk_sys);
		reg_we = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// one read; data lands at the taking edge and is picked up a half cycle on
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_re = 1'b1;
		@(negedge clk_sys);
		reg_re = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
endmodule

// ---- sfc_synth_ctrl_chk.sv ----
// concurrent checks on the ports of the synthesizer control block
`timescale 1ns/1ns
`include "sfc_defs.vh"
module sfc_chk #(
	parameter [31:0] RC_FINE_CYC = 200,
	parameter [31:0] RC_FULL_CYC = 50,
	parameter [31:0] VCO_CAL_CYC = 5,
	parameter [31:0] SETTLE_UNIT_CYC = 3
) (
	input logic clk_sys,
	input logic arst_n,
	input logic [6:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_we,
	input logic reg_re,
	input logic [7:0] reg_rdata,
	input logic [6:0] div_int,
	input logic [15:0] div_frac,
	input logic [6:0] dsm_div,
	input logic div_half_en,
	input logic pll_en,
	input logic vco_cal_busy,
	input logic tx_active,
	input logic rx_active,
	input logic rc_fine_cal,
	input logic rc_full_busy
);
	// ----------------------------------------
	// helper run-length counters
	// ----------------------------------------
	logic [31:0] cal_cnt_reg, full_cnt_reg, gap_cnt_reg, set_cnt_reg; // run lengths
	logic seen_reg; // a fine pulse was seen, so the gap is meaningful
	wire act = tx_active | rx_active; // radio in tx or rx
	// run counts restart when their condition drops; the gap count restarts at each fine pulse
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cal_cnt_reg <= 32'h0;
			full_cnt_reg <= 32'h0;
			gap_cnt_reg <= 32'h0;
			set_cnt_reg <= 32'h0;
			seen_reg <= 1'b0;
		end else begin
			cal_cnt_reg <= vco_cal_busy ? cal_cnt_reg + 32'h1 : 32'h0;
			full_cnt_reg <= rc_full_busy ? full_cnt_reg + 32'h1 : 32'h0;
			gap_cnt_reg <= rc_fine_cal ? 32'h1 : gap_cnt_reg + 32'h1;
			set_cnt_reg <= (pll_en && !vco_cal_busy && !act) ? set_cnt_reg + 32'h1 : 32'h0;
			seen_reg <= seen_reg | rc_fine_cal;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	sequence clamp_wr;
		reg_we && reg_addr == `SFC_ADDR_BAND_SELECT && reg_wdata[4:0] > 5'h17;
	endsequence
	sequence hop_wr;
		act && reg_we && (reg_addr == `SFC_ADDR_HOP_CHANNEL || reg_addr == `SFC_ADDR_HOP_STEP);
	endsequence
	// band flag captured at the write decides the output divider
	property band_div_p;
		(reg_we && reg_addr == `SFC_ADDR_BAND_SELECT) |-> ##2 (div_half_en != $past(reg_wdata[5], 2));
	endproperty
	frac_range_a: assert property (div_frac < 16'hFA00)
		else $error("fraction word not below the modulus");
	carry_step_a: assert property ((div_int == $past(div_int) && div_int == $past(div_int, 2))
		|-> (dsm_div >= div_int && dsm_div <= div_int + 7'h01)) else $error("modulator divide off");
	band_div_a: assert property (band_div_p)
		else $error("output divider does not follow band flag");
	band_clamp_a: assert property (clamp_wr ##2 (reg_re && reg_addr == `SFC_ADDR_BAND_SELECT)
		|=> reg_rdata[4:0] == 5'h17) else $error("band integer not clamped");
	one_mode_a: assert property (!(tx_active && rx_active))
		else $error("tx and rx both active");
	active_pll_a: assert property (act |-> pll_en && !vco_cal_busy)
		else $error("active without a running loop");
	settle_wait_a: assert property ($rose(act) |-> set_cnt_reg >= SETTLE_UNIT_CYC)
		else $error("active before settle time");
	vco_len_a: assert property ($fell(vco_cal_busy) |-> cal_cnt_reg == VCO_CAL_CYC)
		else $error("vco calibration length wrong");
	rc_full_a: assert property ($fell(rc_full_busy) |-> full_cnt_reg == RC_FULL_CYC)
		else $error("full rc calibration length wrong");
	fine_gap_a: assert property (rc_fine_cal && seen_reg |-> gap_cnt_reg == RC_FINE_CYC)
		else $error("fine rc calibration spacing wrong");
	hop_retune_a: assert property (hop_wr |-> ##[1:3] !act ##[1:400] act)
		else $error("hop write did not retune and resume");
endmodule
bind sfc_synth_ctrl sfc_chk #(.RC_FINE_CYC(RC_FINE_CYC), .RC_FULL_CYC(RC_FULL_CYC), .VCO_CAL_CYC(VCO_CAL_CYC),
	.SETTLE_UNIT_CYC(SETTLE_UNIT_CYC)) u_sfc_chk (.clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
	.reg_rdata, .div_int, .div_frac, .dsm_div, .div_half_en, .pll_en, .vco_cal_busy, .tx_active, .rx_active,
	.rc_fine_cal, .rc_full_busy);

// ---- tb.sv ----
// self-checking testbench for the synthesizer control block
`timescale 1ns/1ns
`include "sfc_defs.vh"
module tb;
	localparam int FINE = 200; // shortened fine rc period
	localparam int FULL = 50; // shortened full rc length
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic tx_req = 1'b0, rx_req = 1'b0, tx_data = 1'b0;
	logic [6:0] reg_addr, div_int, dsm_div;
	logic [7:0] reg_wdata, reg_rdata;
	logic [15:0] div_frac;
	logic reg_we, reg_re, div_half_en, pll_en, vco_cal_busy, tx_active, rx_active, rc_fine_cal, rc_full_busy;
	int fails = 0, num_checks = 0;
	// mirror of the programmed frequency settings, reset values
	logic [4:0] band_m = 5'h15;
	logic hb_m = 1'b1;
	logic [15:0] frac_m = 16'h7D00;
	logic [9:0] ofs_m = 10'h000;
	logic [8:0] dev_m = 9'h000;
	logic [7:0] step_m = 8'h00, chan_m = 8'h00;
	wire [4:0] flags = {rc_fine_cal, rc_full_busy, vco_cal_busy, rx_active, tx_active};
	// ----------------------------------------
	// design and host
	// ----------------------------------------
	sfc_synth_ctrl #(.RC_FINE_CYC(FINE), .RC_FULL_CYC(FULL), .VCO_CAL_CYC(5), .BIAS_UNIT_CYC(2),
		.SETTLE_UNIT_CYC(3)) u_sfc_synth_ctrl (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .tx_req(tx_req), .rx_req(rx_req),
		.tx_data(tx_data), .reg_rdata(reg_rdata), .div_int(div_int), .div_frac(div_frac), .dsm_div(dsm_div),
		.div_half_en(div_half_en), .pll_en(pll_en), .vco_cal_busy(vco_cal_busy), .tx_active(tx_active),
		.rx_active(rx_active), .rc_fine_cal(rc_fine_cal), .rc_full_busy(rc_full_busy));
	sfc_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata));
	// free-running 100 MHz clock
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// bounded wait for one status flag; running out ends the run
	task automatic wait_flag(input int i, input logic v, output int n);
		n = 0;
		while (flags[i] !== v) begin
			@(negedge clk_sys);
			n++;
			if (n > 3000) begin
				fails++;
				$display("Error at %0t: wait on flag %0d ran out", $time, i);
				report_and_stop();
			end
		end
	endtask
	// write and keep the mirror in step
	task automatic put(input logic [6:0] a, input logic [7:0] d);
		u_host.wr(a, d);
		case (a)
			`SFC_ADDR_BAND_SELECT: {hb_m, band_m} = {d[5], (d[4:0] > 5'h17) ? 5'h17 : d[4:0]};
			`SFC_ADDR_FRACTION_HI: frac_m[15:8] = d;
			`SFC_ADDR_FRACTION_LO: frac_m[7:0] = d;
			`SFC_ADDR_OFFSET_LO: ofs_m[7:0] = d;
			`SFC_ADDR_OFFSET_HI: ofs_m[9:8] = d[1:0];
			`SFC_ADDR_DEVIATION_LO: dev_m[7:0] = d;
			`SFC_ADDR_DEVIATION_HI: dev_m[8] = d[0];
			`SFC_ADDR_HOP_CHANNEL: chan_m = d;
			`SFC_ADDR_HOP_STEP: step_m = d;
			default: ;
		endcase
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] v;
		u_host.rd(a, v);
		check(v, exp);
	endtask
	// expected divide word; mode 0 idle, 1 tx, 2 rx
	task automatic check_word(input int m);
		int w;
		repeat (4) @(negedge clk_sys);
		w = int'($signed(ofs_m));
		w = w + (int'(band_m) + 24) * 64000 + int'(frac_m) + int'(step_m) * int'(chan_m) * (hb_m ? 32 : 64);
		if (m == 1) w = w + (tx_data ? 1 : -1) * int'(dev_m) * (hb_m ? 2 : 4);
		if (m == 2) w = w - (hb_m ? 3000 : 6000);
		check(div_int, w / 64000);
		check(div_frac, w % 64000);
		check(div_half_en, !hb_m);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int n;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		arst_n = 1'b1;
		rd_chk(`SFC_ADDR_PLL_TUNE_TIMING, 8'hA2);
		rd_chk(`SFC_ADDR_CALIBRATION_CONTROL, 8'h00);
		rd_chk(`SFC_ADDR_BAND_SELECT, 8'h35);
		rd_chk(`SFC_ADDR_HOP_CHANNEL, 8'h00);
		rd_chk(`SFC_ADDR_HOP_STEP, 8'h00);
		rd_chk(7'h78, 8'h00);
		check_word(0);
		$display("test reset values done");
		put(`SFC_ADDR_BAND_SELECT, 8'h1F);
		rd_chk(`SFC_ADDR_BAND_SELECT, 8'h17);
		check_word(0);
		$display("test band clamp done");
		put(`SFC_ADDR_BAND_SELECT, 8'h35);
		put(`SFC_ADDR_FRACTION_HI, 8'hF9);
		put(`SFC_ADDR_FRACTION_LO, 8'hFF);
		put(`SFC_ADDR_OFFSET_LO, 8'h02);
		check_word(0);
		put(`SFC_ADDR_OFFSET_LO, 8'hFE);
		put(`SFC_ADDR_OFFSET_HI, 8'h03);
		rd_chk(`SFC_ADDR_OFFSET_HI, 8'h03);
		check_word(0);
		put(`SFC_ADDR_HOP_STEP, 8'h05);
		put(`SFC_ADDR_HOP_CHANNEL, 8'h03);
		check_word(0);
		put(`SFC_ADDR_BAND_SELECT, 8'h15);
		check_word(0);
		$display("test word arithmetic done");
		put(`SFC_ADDR_PLL_TUNE_TIMING, 8'h09);
		put(`SFC_ADDR_DEVIATION_LO, 8'h10);
		put(`SFC_ADDR_DEVIATION_HI, 8'h01);
		rd_chk(`SFC_ADDR_DEVIATION_HI, 8'h01);
		tx_data = 1'b1;
		tx_req = 1'b1;
		wait_flag(0, 1'b1, n);
		check_word(1);
		tx_data = 1'b0;
		check_word(1);
		rx_req = 1'b1;
		tx_req = 1'b0;
		wait_flag(1, 1'b1, n);
		check_word(2);
		put(`SFC_ADDR_HOP_CHANNEL, 8'h04);
		wait_flag(1, 1'b0, n);
		wait_flag(1, 1'b1, n);
		check_word(2);
		put(`SFC_ADDR_CALIBRATION_CONTROL, 8'h01);
		wait_flag(2, 1'b1, n);
		wait_flag(2, 1'b0, n);
		check(n, 5);
		wait_flag(1, 1'b1, n);
		rx_req = 1'b0;
		repeat (3) @(negedge clk_sys);
		check(pll_en, 1'b0);
		$display("test tx rx retune done");
		put(`SFC_ADDR_CALIBRATION_CONTROL, 8'h04);
		wait_flag(3, 1'b1, n);
		wait_flag(3, 1'b0, n);
		check(n, FULL);
		rd_chk(`SFC_ADDR_CALIBRATION_CONTROL, 8'h00);
		put(`SFC_ADDR_CALIBRATION_CONTROL, 8'h02);
		wait_flag(4, 1'b1, n);
		wait_flag(4, 1'b0, n);
		wait_flag(4, 1'b1, n);
		check(n + 1, FINE);
		$display("test rc calibration done");
		report_and_stop();
	end
endmodule
